// [hw/hwmon_gate_map.svh]
// Register map, field layout, reset values and timing constants of the gating and trim block
`ifndef HWMON_GATE_MAP_SVH
`define HWMON_GATE_MAP_SVH

`define ADDR_W              8
`define DATA_W              8
`define CH_N                5
`define TEMP_W              8

`define OFF_GATING_CFG      8'h79
`define OFF_ZONE1_TRIM      8'h7d
`define OFF_CTRL            8'h70

`define GATE_RAIL12_BIT     4
`define GATE_RAIL5_BIT      3
`define GATE_RAIL3P3_BIT    2
`define GATE_CORE_BIT       1
`define GATE_RAIL2P5_BIT    0
`define GATE_RESET          5'h02

`define TRIM_GAIN_HI        7
`define TRIM_GAIN_LO        6
`define TRIM_OFS_HI         3
`define TRIM_OFS_LO         0
`define TRIM_RESET          8'h00
`define TRIM_WR_MASK        8'hcf

`define CTRL_LOCK_BIT       0

`define TEMP_ERR_VALUE      8'h80

`define GAIN_UNITY          2'h0
`define GAIN_UP_1           2'h1
`define GAIN_DN_2           2'h2
`define GAIN_DN_1           2'h3

`define CLK_MHZ             100
`define RELEASE_DELAY_MS    182
`define RELEASE_CYCLES      (`RELEASE_DELAY_MS * 1000 * `CLK_MHZ)
`define CNT_W               25

`endif

// [hw/hwmon_gate_pkg.sv]
// Types shared by the gating and trim block
package hwmon_gate_pkg;

    typedef enum logic [1:0] {
        GATE_ACTIVE  = 2'b00,
        GATE_OFF     = 2'b01,
        GATE_WAITING = 2'b10
    } gate_state_e;

    typedef logic [7:0] temp_t;

endpackage

// [hw/trim_if.sv]
// Interface carrying zone-1 sample and trim settings to the trim datapath
`timescale 1ns/1ps
`default_nettype none

interface trim_if;
    logic       in_valid;
    logic [7:0] in_data;
    logic       conn_err;
    logic [1:0] gain_sel;
    logic [3:0] offset;
    logic       out_valid;
    logic [7:0] out_data;

    modport ctrl (output in_valid, output in_data, output conn_err, output gain_sel,
                  output offset, input out_valid, input out_data);
    modport dp   (input in_valid, input in_data, input conn_err, input gain_sel,
                  input offset, output out_valid, output out_data);
endinterface

`default_nettype wire

// [hw/zone1_trim_dp.sv]
// Zone-1 temperature gain and offset correction datapath
`timescale 1ns/1ps
`default_nettype none
`include "hwmon_gate_map.svh"

module zone1_trim_dp
    import hwmon_gate_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic arst_n,
    trim_if.dp        t
);
    logic signed [9:0]  x;
    logic signed [9:0]  g;
    logic signed [10:0] s;
    temp_t              next_out;

    // Data is two's complement degrees; gain via shift-and-add, the arithmetic shift drops the fraction of the scaled term
    always_comb begin
        x = 10'(signed'(t.in_data));
        case (t.gain_sel)
            `GAIN_UP_1: g = x + (x >>> 7);
            `GAIN_DN_1: g = x - (x >>> 7);
            `GAIN_DN_2: g = x - (x >>> 6);
            default:    g = x;
        endcase
        s = 11'(g) + 11'(signed'(t.offset));
        if (t.conn_err) begin
            next_out = `TEMP_ERR_VALUE;
        end else if (s > 11'sd127) begin
            next_out = 8'h7f;
        end else if (s < -11'sd127) begin
            next_out = 8'h81;
        end else begin
            next_out = s[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            t.out_valid <= 1'b0;
            t.out_data  <= 8'h00;
        end else begin
            t.out_valid <= t.in_valid;
            if (t.in_valid) begin
                t.out_data <= next_out;
            end
        end
    end
endmodule

`default_nettype wire

// [hw/supply_release_timer.sv]
// Counts the release delay after the main supply returns
`timescale 1ns/1ps
`default_nettype none
`include "hwmon_gate_map.svh"

module supply_release_timer #(
    parameter int unsigned RELEASE_CYCLES = `RELEASE_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic main_supply,
    output var  logic released
);
    logic [`CNT_W-1:0] count;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count    <= '0;
            released <= 1'b0;
        end else if (!main_supply) begin
            count    <= '0;
            released <= 1'b0;
        end else if (!released) begin
            if (count == `CNT_W'(RELEASE_CYCLES - 1)) begin
                released <= 1'b1;
            end else begin
                count <= count + `CNT_W'(1);
            end
        end
    end
endmodule

`default_nettype wire

// [hw/hwmon_channel_gating_temp_trim.sv]
// Voltage channel supply gating and zone-1 temperature trim, top level
//
// Contract
// - gated channels stop and clear flags while supply off
// - wait 182 ms after supply returns
// - gate bits 4..0 are 12V,5V,3.3V,core,2.5V
// - core gate resets 1, others 0
// - ungated channels ignore main supply state
// - lock bit freezes the trim register
// - gain codes 00,01,11,10 give fixed multipliers
// - gain multiplies converted zone-1 data
// - offset is signed 4-bit degrees added
// - offset 7h +7, 0h none, Fh -1, 8h -8
// - connection error skips gain, forces 80h; code does so only while remote_diode is set
// - connection error skips offset too
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "hwmon_gate_map.svh"

module hwmon_channel_gating_temp_trim
    import hwmon_gate_pkg::*;
#(
    parameter int unsigned RELEASE_CYCLES = `RELEASE_CYCLES
) (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [`DATA_W-1:0]   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output var  logic [`DATA_W-1:0]   reg_rdata,
    input  wire logic                 main_supply,
    input  wire logic [`CH_N-1:0]     ch_status_in,
    output var  logic [`CH_N-1:0]     ch_monitor_en,
    output var  logic [`CH_N-1:0]     ch_status,
    input  wire logic                 temp_in_valid,
    input  wire logic [`TEMP_W-1:0]   temp_in_data,
    input  wire logic                 remote_diode,
    input  wire logic                 sensor_conn_err,
    output var  logic                 temp_out_valid,
    output var  logic [`TEMP_W-1:0]   temp_out_data
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [`CH_N-1:0] gating_sel;
    logic [7:0]       zone1_trim;
    logic             cfg_lock;
    logic             released;
    gate_state_e      gate_state;

    logic wr_gate;
    logic wr_trim;
    logic wr_ctrl;

    assign wr_gate = reg_wr && (reg_addr == `OFF_GATING_CFG);
    assign wr_trim = reg_wr && (reg_addr == `OFF_ZONE1_TRIM);
    assign wr_ctrl = reg_wr && (reg_addr == `OFF_CTRL);

    // Lock can only be set; it clears at reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_lock <= 1'b0;
        end else if (wr_ctrl && reg_wdata[`CTRL_LOCK_BIT]) begin
            cfg_lock <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gating_sel <= `GATE_RESET;
        end else if (wr_gate && !cfg_lock) begin
            gating_sel <= reg_wdata[`CH_N-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            zone1_trim <= `TRIM_RESET;
        end else if (wr_trim && !cfg_lock) begin
            zone1_trim <= reg_wdata & `TRIM_WR_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFF_GATING_CFG: reg_rdata <= {3'h0, gating_sel};
                `OFF_ZONE1_TRIM: reg_rdata <= zone1_trim;
                `OFF_CTRL:       reg_rdata <= {7'h00, cfg_lock};
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply gating

    supply_release_timer #(
        .RELEASE_CYCLES (RELEASE_CYCLES)
    ) supply_release_timer_inst (
        .sys_clk     (sys_clk),
        .arst_n      (arst_n),
        .main_supply (main_supply),
        .released    (released)
    );

    // Internal sequencing state of the main supply, not on any port or register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_state <= GATE_OFF;
        end else begin
            case (gate_state)
                GATE_ACTIVE:  if (!main_supply) gate_state <= GATE_OFF;
                GATE_OFF:     if (main_supply) gate_state <= GATE_WAITING;
                GATE_WAITING: begin
                    if (!main_supply) begin
                        gate_state <= GATE_OFF;
                    end else if (released) begin
                        gate_state <= GATE_ACTIVE;
                    end
                end
                default:      gate_state <= GATE_OFF;
            endcase
        end
    end

    logic supply_ok;
    assign supply_ok = released && main_supply && (gate_state != GATE_OFF);

    genvar ch;
    generate
        for (ch = 0; ch < `CH_N; ch++) begin : g_ch
            logic hold;
            assign hold = gating_sel[ch] && !supply_ok;
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    ch_monitor_en[ch] <= 1'b0;
                    ch_status[ch]     <= 1'b0;
                end else begin
                    ch_monitor_en[ch] <= !hold;
                    ch_status[ch]     <= hold ? 1'b0 : ch_status_in[ch];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Zone-1 temperature trim

    trim_if t_if ();

    assign t_if.in_valid = temp_in_valid;
    assign t_if.in_data  = temp_in_data;
    assign t_if.conn_err = sensor_conn_err && remote_diode;
    assign t_if.gain_sel = zone1_trim[`TRIM_GAIN_HI:`TRIM_GAIN_LO];
    assign t_if.offset   = zone1_trim[`TRIM_OFS_HI:`TRIM_OFS_LO];

    zone1_trim_dp zone1_trim_dp_inst (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .t       (t_if.dp)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_out_valid <= 1'b0;
            temp_out_data  <= 8'h00;
        end else begin
            temp_out_valid <= t_if.out_valid;
            temp_out_data  <= t_if.out_data;
        end
    end

endmodule

`default_nettype wire

// [testbench/gate_checker_assertions.sv]
// Port-level checks of the gating and trim block
`timescale 1ns/1ps
`default_nettype none
module gate_checker #(
    parameter int unsigned RELEASE_CYCLES = 20
) (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       main_supply,
    input wire logic [4:0] ch_monitor_en,
    input wire logic [4:0] ch_status,
    input wire logic       temp_in_valid,
    input wire logic       remote_diode,
    input wire logic       sensor_conn_err,
    input wire logic       temp_out_valid,
    input wire logic [7:0] temp_out_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    int unsigned on_cnt;
    logic        up;
    ////////////////////////////////////////////////////////////////
    // Unbroken on-time of the main supply
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            on_cnt <= 0;
        else if (!main_supply)
            on_cnt <= 0;
        else if (on_cnt < RELEASE_CYCLES + 8)
            on_cnt <= on_cnt + 1;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            up <= 1'b0;
        else
            up <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    sequence s_off_hold;
        (!main_supply && !reg_wr)[*3];
    endsequence
    sequence s_err_in;
        temp_in_valid && sensor_conn_err && remote_diode;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_trim_reserved: assert property (reg_rd && reg_addr == 8'h7d |=> reg_rdata[5:4] == 2'b00)
        else $error("reserved bits not zero");
    a_gate_upper: assert property (reg_rd && reg_addr == 8'h79 |=> reg_rdata[7:5] == 3'h0)
        else $error("gating upper bits set");
    a_temp_latency: assert property (temp_in_valid |-> ##2 temp_out_valid)
        else $error("sample result missing");
    a_temp_origin: assert property (temp_out_valid |-> $past(temp_in_valid, 2))
        else $error("result without sample");
    a_err_value: assert property (s_err_in |-> ##2 temp_out_data == 8'h80)
        else $error("error value not forced");
    a_status_masked: assert property ((ch_status & ~ch_monitor_en) == 5'h00)
        else $error("flag on stopped channel");
    a_no_wake: assert property (s_off_hold |=> (ch_monitor_en & ~$past(ch_monitor_en)) == 5'h00)
        else $error("channel woke without supply");
    a_release_wait: assert property (up && $past(up) && !$past(reg_wr) && !$past(reg_wr, 2)
        && (ch_monitor_en & ~$past(ch_monitor_en)) != 5'h00 |-> on_cnt >= RELEASE_CYCLES)
        else $error("channel woke early");
endmodule
bind hwmon_channel_gating_temp_trim gate_checker #(.RELEASE_CYCLES(RELEASE_CYCLES)) gate_checker_inst (
    .sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .main_supply, .ch_monitor_en,
    .ch_status, .temp_in_valid, .remote_diode, .sensor_conn_err, .temp_out_valid, .temp_out_data
);
`default_nettype wire

// [testbench/test_hwmon_channel_gating_temp_trim.sv]
// Self-checking bench of the gating and trim block
`timescale 1ns/1ps
`default_nettype none
module test_hwmon_channel_gating_temp_trim;
    localparam int unsigned RC = 20;
    localparam logic [3:0] OFS [4] = '{4'h7, 4'h0, 4'hf, 4'h8};
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        main_supply = 1'b0;
    logic [4:0]  ch_status_in = 5'h00;
    logic        temp_in_valid = 1'b0;
    logic [7:0]  temp_in_data = 8'h00;
    logic        remote_diode = 1'b0;
    logic        sensor_conn_err = 1'b0;
    logic [7:0]  reg_rdata, temp_out_data;
    logic [4:0]  ch_monitor_en, ch_status;
    logic        temp_out_valid;
    logic        rd_d = 1'b0;
    logic [31:0] rnd = 32'd89;
    logic [7:0]  rd_q[$], tp_q[$];
    int          fails = 0;
    int          num_checks = 0;
    int          cyc = 0;

    always #5 sys_clk = ~sys_clk;

    hwmon_channel_gating_temp_trim #(.RELEASE_CYCLES(RC)) hwmon_channel_gating_temp_trim_inst (
        .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .main_supply,
        .ch_status_in, .ch_monitor_en, .ch_status, .temp_in_valid, .temp_in_data,
        .remote_diode, .sensor_conn_err, .temp_out_valid, .temp_out_data
    );
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd[7:0];
    endfunction
    // Gain first, then signed offset, then saturation
    function automatic logic [7:0] trim(input logic [7:0] x, input logic [1:0] g,
                                        input logic [3:0] o);
        int v;
        v = $signed(x);
        case (g)
            2'h1: v = v + (v >>> 7);
            2'h2: v = v - (v >>> 6);
            2'h3: v = v - (v >>> 7);
            default: v = v;
        endcase
        v = v + $signed(o);
        if (v > 127) v = 127;
        if (v < -127) v = -127;
        return v[7:0];
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    task tmp(input logic [7:0] x, input logic err, input logic [7:0] e);
        @(posedge sys_clk);
        temp_in_valid <= 1'b1;
        temp_in_data <= x;
        sensor_conn_err <= err;
        tp_q.push_back(e);
        @(posedge sys_clk);
        temp_in_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task lvl(input logic [4:0] en, input logic [4:0] st);
        @(negedge sys_clk);
        chk(8'(ch_monitor_en), 8'(en));
        chk(8'(ch_status), 8'(st));
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) rd_d <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_d) chk(reg_rdata, rd_q.pop_front());
        if (temp_out_valid === 1'b1) chk(temp_out_data, tp_q.pop_front());
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        logic [7:0] x;
        logic [1:0] g;
        logic [3:0] o;
        repeat (16) @(posedge sys_clk);
        x = xs();
        arst_n <= 1'b1;
        ch_status_in <= x[4:0];
        rd(8'h7d, 8'h00);
        rd(8'h79, 8'h02);
        rd(8'h11, 8'h00);
        lvl(5'h1d, ch_status_in & 5'h1d);
        @(posedge sys_clk);
        main_supply <= 1'b1;
        repeat (RC) @(posedge sys_clk);
        lvl(5'h1d, ch_status_in & 5'h1d);
        lvl(5'h1f, ch_status_in);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(8'h79, 8'h01 << i);
            rd(8'h79, 8'h01 << i);
            main_supply <= 1'b0;
            repeat (4) @(posedge sys_clk);
            lvl(5'h1f ^ (5'h01 << i), ch_status_in & ~(5'h01 << i));
            @(posedge sys_clk);
            main_supply <= 1'b1;
            repeat (RC + 6) @(posedge sys_clk);
            lvl(5'h1f, ch_status_in);
        end
        $display("test gating done");
        for (int i = 0; i < 16; i++) begin
            g = i[1:0];
            o = OFS[i[3:2]];
            wr(8'h7d, {g, 2'b11, o});
            rd(8'h7d, {g, 2'b00, o});
            x = (i == 0) ? 8'h7f : (i == 12) ? 8'h81 : xs();
            remote_diode <= i[0];
            tmp(x, 1'b0, trim(x, g, o));
            tmp(x, 1'b1, i[0] ? 8'h80 : trim(x, g, o));
        end
        $display("test trim done");
        rd(8'h70, 8'h00);
        wr(8'h70, 8'h01);
        rd(8'h70, 8'h01);
        wr(8'h7d, 8'h41);
        rd(8'h7d, 8'hc8);
        wr(8'h79, 8'h1f);
        rd(8'h79, 8'h10);
        $display("test lock done");
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(8'h70, 8'h00);
        rd(8'h7d, 8'h00);
        rd(8'h79, 8'h02);
        lvl(5'h1d, ch_status_in & 5'h1d);
        $display("test second reset done");
        repeat (4) @(posedge sys_clk);
        stop_test();
    end
endmodule
`default_nettype wire
